// ===== common/spwm_params.svh
// Constants for the switch PWM and interval timer block
`ifndef SPWM_PARAMS_SVH
`define SPWM_PARAMS_SVH

// Clock and time bases
`define SPWM_CLK_NS 10
`define SPWM_PER200_NS 5000000
`define SPWM_PER400_NS 2500000
`define SPWM_TICK_US 100

// PWM resolution
`define SPWM_PWM_STEPS 1023
`define SPWM_DUTY_ZERO 10'h000
`define SPWM_DUTY_FULL 10'h3FF

// Register indices; byte address is four times the index
`define SPWM_IDX_CTRL 6'h1E
`define SPWM_IDX_FREQ 6'h22
`define SPWM_IDX_DHI 6'h23
`define SPWM_IDX_DLO 6'h24
`define SPWM_IDX_TMA 6'h25
`define SPWM_IDX_TMB 6'h26
`define SPWM_IDX_STAT 6'h30

// Field positions
`define SPWM_EN_BIT 7
`define SPWM_SRC_HI 6
`define SPWM_SRC_LO 4
`define SPWM_FREQ_BIT 7
`define SPWM_DHI_HI 1
`define SPWM_WID_HI 7
`define SPWM_WID_LO 4
`define SPWM_PER_HI 2

// Reset values
`define SPWM_RST_BYTE 8'h00
`define SPWM_RST_SRC 3'h0
`define SPWM_RST_DHI 2'h0
`define SPWM_RST_WID 4'h0
`define SPWM_RST_PER 3'h0

// On-width codes with fixed meaning
`define SPWM_WID_OFF 4'h0
`define SPWM_WID_ON 4'hF

// Microseconds to ticks of the timer base
`define SPWM_T(us) (15'((us) / `SPWM_TICK_US))

`endif

// ===== common/spwm_pkg.sv
// Types and decode functions for the switch PWM and interval timer block
`include "spwm_params.svh"

package spwm_pkg;

    // Bus handshake states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_ACK = 2'h2
    } spwm_bus_e;

    // Switch drive sources
    typedef enum logic [2:0] {
        SRC_ONOFF = 3'h0,
        SRC_PWM_A = 3'h1,
        SRC_PWM_B = 3'h2,
        SRC_TIM_A = 3'h3,
        SRC_TIM_B = 3'h4,
        SRC_ALT = 3'h5
    } spwm_src_e;

    typedef struct packed {
        logic [14:0] cnt;
        logic on;
        logic hiz;
    } spwm_tim_s;

    // On-width code to ticks (printed figures in microseconds)
    function automatic logic [14:0] width_ticks(input logic [3:0] code);
        case (code)
            4'h1: width_ticks = `SPWM_T(100);
            4'h2: width_ticks = `SPWM_T(300);
            4'h3: width_ticks = `SPWM_T(500);
            4'h4: width_ticks = `SPWM_T(1000);
            4'h5: width_ticks = `SPWM_T(10000);
            4'h6: width_ticks = `SPWM_T(20000);
            4'h7: width_ticks = `SPWM_T(30000);
            4'h8: width_ticks = `SPWM_T(40000);
            4'h9: width_ticks = `SPWM_T(50000);
            4'hA: width_ticks = `SPWM_T(60000);
            4'hB: width_ticks = `SPWM_T(80000);
            4'hC: width_ticks = `SPWM_T(100000);
            4'hD: width_ticks = `SPWM_T(150000);
            4'hE: width_ticks = `SPWM_T(200000);
            default: width_ticks = 15'h0000;
        endcase
    endfunction

    // Period code to ticks
    function automatic logic [14:0] period_ticks(input logic [2:0] code);
        case (code)
            3'h0: period_ticks = `SPWM_T(10000);
            3'h1: period_ticks = `SPWM_T(20000);
            3'h2: period_ticks = `SPWM_T(50000);
            3'h3: period_ticks = `SPWM_T(100000);
            3'h4: period_ticks = `SPWM_T(200000);
            3'h5: period_ticks = `SPWM_T(500000);
            3'h6: period_ticks = `SPWM_T(1000000);
            default: period_ticks = `SPWM_T(2000000);
        endcase
    endfunction

endpackage

// ===== hdl/spwm_interval_timer.sv
// One interval timer: on-pulse at the start of each repeat period
`include "spwm_params.svh"
module spwm_interval_timer
    import spwm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic [3:0] width_i,
    input wire logic [2:0] period_i,
    output logic on_o,
    output logic hiz_o
);

    spwm_tim_s r;
    spwm_tim_s next_r;
    logic [14:0] per;
    logic [14:0] wid;

    // Period counter and pulse decode
    always_comb begin
        next_r = r;
        per = period_ticks(period_i);
        wid = width_ticks(width_i);
        // Wrap also when a shorter period was just written
        if (tick_i) begin
            if (r.cnt >= 15'(per - 15'h0001)) begin
                next_r.cnt = 15'h0000; // RL13
            end else begin
                next_r.cnt = 15'(r.cnt + 15'h0001);
            end
        end
        next_r.hiz = (width_i == `SPWM_WID_OFF); // RL6
        // Width above period simply stays on the whole period
        next_r.on = (width_i == `SPWM_WID_ON) ||
                    ((width_i != `SPWM_WID_OFF) && (r.cnt < wid)); // RL6 RL7 RL8 RL13
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign on_o = r.on;
    assign hiz_o = r.hiz;

endmodule

// ===== hdl/spwm_top.sv
// Switch drive generator: second PWM channel, two interval timers, APB registers
//
// What this block does, and what software must do
// RL1 - Second PWM duty is 2 upper bits in one register, 8 lower in next.
// RL2 - Duty code zero keeps the switch off the whole period.
// RL3 - Duty code all ones keeps the switch on the whole period.
// RL4 - Each duty step adds about one thousandth of the period on-time.
// RL5 - Software avoids tiny non-zero duty codes the switch cannot resolve.
// RL6 - Timer on-width code zero is high impedance, code fifteen fully on.
// RL7 - On-width codes 1 to 14 give 0.1 ms up to 200 ms ascending.
// RL8 - Period codes 0 to 7 give 10 ms up to 2000 ms.
// RL9 - Software keeps timer on-width no longer than its period.
// RL10 - Second timer has identical fields; its bit three reads zero.
// RL11 - Three-bit source select picks on/off, PWMs, timers or alternate input.
// RL12 - Second PWM runs at 200 Hz or 400 Hz by its frequency bit.
// RL13 - Timer turns switch on at period start for on-width, then off.
// RL14 - Reserved register bits read zero and ignore writes.
`include "spwm_params.svh"
module spwm_top
    import spwm_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `SPWM_TICK_US * 1000 / `SPWM_CLK_NS
)
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic PWM_A_I,
    input wire logic ALT_CTRL_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic SWITCH_ON_O,
    output logic SWITCH_HIZ_O
);

    // Step lengths per duty count, rounded down
    localparam int unsigned STEP_200 =
        `SPWM_PER200_NS / (`SPWM_CLK_NS * `SPWM_PWM_STEPS);
    localparam int unsigned STEP_400 =
        `SPWM_PER400_NS / (`SPWM_CLK_NS * `SPWM_PWM_STEPS);
    localparam logic [9:0] STEP_LAST_200 = 10'(STEP_200 - 1);
    localparam logic [9:0] STEP_LAST_400 = 10'(STEP_400 - 1);
    localparam logic [9:0] POS_LAST = 10'(`SPWM_PWM_STEPS - 1);
    localparam logic [13:0] TICK_LAST = 14'(TICK_CYCLES - 1);

    typedef struct packed {
        spwm_bus_e st;
        logic pready;
        logic pslverr;
        logic [7:0] rdata;
        logic sw_en;
        logic [2:0] src;
        logic freq_b;
        logic [1:0] duty_hi;
        logic [7:0] duty_lo;
        logic [3:0] wid_a;
        logic [2:0] per_a;
        logic [3:0] wid_b;
        logic [2:0] per_b;
        logic [9:0] step_cnt;
        logic [9:0] pos;
        logic pwm_b;
        logic [13:0] tick_cnt;
        logic tick;
        logic alt_s1;
        logic alt_s2;
        logic alt_s3;
        logic alt;
        logic sw_on;
        logic sw_hiz;
    } spwm_top_s;

    spwm_top_s r;
    spwm_top_s next_r;

    logic tim_a_on;
    logic tim_a_hiz;
    logic tim_b_on;
    logic tim_b_hiz;
    logic [5:0] idx;
    logic hit;
    logic [7:0] rd_val;
    logic [9:0] duty;
    logic [9:0] step_last;

    // Both timers share the 0.1 ms tick
    spwm_interval_timer u_timer_a (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .tick_i(r.tick),
        .width_i(r.wid_a),
        .period_i(r.per_a),
        .on_o(tim_a_on),
        .hiz_o(tim_a_hiz)
    );

    spwm_interval_timer u_timer_b (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .tick_i(r.tick),
        .width_i(r.wid_b), // RL10
        .period_i(r.per_b), // RL10
        .on_o(tim_b_on),
        .hiz_o(tim_b_hiz)
    );

    // Address decode and read mux; spare bits return zero
    always_comb begin
        idx = PADDR_I[7:2];
        hit = (PADDR_I[1:0] == 2'h0);
        rd_val = `SPWM_RST_BYTE;
        case (idx)
            `SPWM_IDX_CTRL: begin
                rd_val[`SPWM_EN_BIT] = r.sw_en;
                rd_val[`SPWM_SRC_HI:`SPWM_SRC_LO] = r.src; // RL14
            end
            `SPWM_IDX_FREQ: begin
                rd_val[`SPWM_FREQ_BIT] = r.freq_b;
            end
            `SPWM_IDX_DHI: begin
                rd_val[`SPWM_DHI_HI:0] = r.duty_hi; // RL14
            end
            `SPWM_IDX_DLO: begin
                rd_val = r.duty_lo;
            end
            `SPWM_IDX_TMA: begin
                rd_val[`SPWM_WID_HI:`SPWM_WID_LO] = r.wid_a;
                rd_val[`SPWM_PER_HI:0] = r.per_a; // RL14
            end
            `SPWM_IDX_TMB: begin
                rd_val[`SPWM_WID_HI:`SPWM_WID_LO] = r.wid_b;
                rd_val[`SPWM_PER_HI:0] = r.per_b; // RL10
            end
            `SPWM_IDX_STAT: begin
                rd_val[0] = r.sw_on;
                rd_val[1] = r.sw_hiz;
                rd_val[2] = r.pwm_b;
                rd_val[3] = tim_a_on;
                rd_val[4] = tim_b_on;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Main next-state logic
    always_comb begin
        next_r = r;
        duty = {r.duty_hi, r.duty_lo}; // RL1
        step_last = r.freq_b ? STEP_LAST_400 : STEP_LAST_200; // RL12

        // APB: one wait-free access cycle; write lands at completion edge
        case (r.st)
            ST_IDLE: begin
                if (PSEL_I && !PENABLE_I) begin
                    next_r.st = ST_ACK;
                    next_r.pready = 1'b1;
                    next_r.pslverr = !hit;
                    // Refused reads answer zero, never the decoded register
                    next_r.rdata = (PWRITE_I || !hit) ? `SPWM_RST_BYTE : rd_val; // RL14
                end
            end
            ST_ACK: begin
                next_r.st = ST_IDLE;
                next_r.pready = 1'b0;
                next_r.pslverr = 1'b0;
                next_r.rdata = `SPWM_RST_BYTE;
                if (PSEL_I && PENABLE_I && PWRITE_I && hit) begin
                    case (idx)
                        `SPWM_IDX_CTRL: begin
                            next_r.sw_en = PWDATA_I[`SPWM_EN_BIT];
                            next_r.src = PWDATA_I[`SPWM_SRC_HI:`SPWM_SRC_LO]; // RL11
                        end
                        `SPWM_IDX_FREQ: begin
                            next_r.freq_b = PWDATA_I[`SPWM_FREQ_BIT]; // RL12
                        end
                        `SPWM_IDX_DHI: begin
                            next_r.duty_hi = PWDATA_I[`SPWM_DHI_HI:0]; // RL1 RL14
                        end
                        `SPWM_IDX_DLO: begin
                            next_r.duty_lo = PWDATA_I[7:0]; // RL1
                        end
                        `SPWM_IDX_TMA: begin
                            next_r.wid_a = PWDATA_I[`SPWM_WID_HI:`SPWM_WID_LO]; // RL6
                            next_r.per_a = PWDATA_I[`SPWM_PER_HI:0]; // RL8
                        end
                        `SPWM_IDX_TMB: begin
                            next_r.wid_b = PWDATA_I[`SPWM_WID_HI:`SPWM_WID_LO]; // RL10
                            next_r.per_b = PWDATA_I[`SPWM_PER_HI:0]; // RL10
                        end
                        default: begin
                            next_r.sw_en = r.sw_en;
                        end
                    endcase
                end
            end
            default: begin
                next_r.st = ST_IDLE;
                next_r.pready = 1'b0;
                next_r.pslverr = 1'b0;
            end
        endcase

        // PWM step divider; 1023 positions so each code is ~0.1 %
        if (r.step_cnt >= step_last) begin
            next_r.step_cnt = 10'h000;
            if (r.pos >= POS_LAST) begin
                next_r.pos = 10'h000;
            end else begin
                next_r.pos = 10'(r.pos + 10'h001); // RL4
            end
        end else begin
            next_r.step_cnt = 10'(r.step_cnt + 10'h001);
        end

        // Compare; codes too small for the switch still pass through as is
        if (duty == `SPWM_DUTY_ZERO) begin
            next_r.pwm_b = 1'b0; // RL2
        end else if (duty == `SPWM_DUTY_FULL) begin
            next_r.pwm_b = 1'b1; // RL3
        end else begin
            next_r.pwm_b = (r.pos < duty); // RL4
        end

        // Timer base tick, one cycle every 0.1 ms
        next_r.tick = 1'b0;
        if (r.tick_cnt >= TICK_LAST) begin
            next_r.tick_cnt = 14'h0000;
            next_r.tick = 1'b1;
        end else begin
            next_r.tick_cnt = 14'(r.tick_cnt + 14'h0001);
        end

        // Alternate control pin: take a change once stages two and three agree
        next_r.alt_s1 = ALT_CTRL_I;
        next_r.alt_s2 = r.alt_s1;
        next_r.alt_s3 = r.alt_s2;
        if (r.alt_s2 == r.alt_s3) begin
            next_r.alt = r.alt_s3;
        end

        // Switch source mux; disabled switch floats
        next_r.sw_on = 1'b0;
        next_r.sw_hiz = 1'b0;
        if (!r.sw_en) begin
            next_r.sw_hiz = 1'b1;
        end else begin
            case (r.src)
                SRC_ONOFF: next_r.sw_on = 1'b1; // RL11
                SRC_PWM_A: next_r.sw_on = PWM_A_I; // RL11
                SRC_PWM_B: next_r.sw_on = r.pwm_b; // RL11
                SRC_TIM_A: begin
                    next_r.sw_on = tim_a_on; // RL11
                    next_r.sw_hiz = tim_a_hiz; // RL6
                end
                SRC_TIM_B: begin
                    next_r.sw_on = tim_b_on; // RL11
                    next_r.sw_hiz = tim_b_hiz; // RL10
                end
                SRC_ALT: next_r.sw_on = r.alt; // RL11
                default: next_r.sw_on = 1'b0; // RL11
            endcase
        end
    end

    // State register
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.src <= `SPWM_RST_SRC;
            r.duty_hi <= `SPWM_RST_DHI;
            r.duty_lo <= `SPWM_RST_BYTE;
            r.wid_a <= `SPWM_RST_WID;
            r.per_a <= `SPWM_RST_PER;
            r.wid_b <= `SPWM_RST_WID;
            r.per_b <= `SPWM_RST_PER;
            r.sw_hiz <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flops; upper read bits are constant zero
    assign PRDATA_O = {24'h000000, r.rdata};
    assign PREADY_O = r.pready;
    assign PSLVERR_O = r.pslverr;
    assign SWITCH_ON_O = r.sw_on;
    assign SWITCH_HIZ_O = r.sw_hiz;

endmodule

// ===== sim/spwm_load_model.sv
// Lamp load on the switch output: measures on-width and repeat period
module spwm_load_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic on_i,
    input wire logic hiz_i,
    output logic done_o,
    output int width_o,
    output int period_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lit;
    logic prev;
    int cnt_on;
    int cnt_per;

    // Lamp glows only when the switch is driven on
    assign lit = on_i && !hiz_i;

    // Count lit cycles and rise-to-rise spacing; done pulses at each fall
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            prev <= 1'b0;
            cnt_on <= 0;
            cnt_per <= 0;
        end else begin
            prev <= lit;
            cnt_per <= (lit && !prev) ? 1 : cnt_per + 1;
            cnt_on <= lit ? cnt_on + 1 : 0;
            if (lit && !prev) period_o <= cnt_per;
            if (!lit && prev) begin
                width_o <= cnt_on;
                done_o <= 1'b1;
            end
        end
    end
endmodule

// ===== sim/spwm_top_checker.sv
// Port-level assertions for the switch PWM and interval timer block
`include "spwm_params.svh"
module spwm_top_checker (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic SWITCH_ON_O,
    input wire logic SWITCH_HIZ_O
);
    logic setup;
    logic rd_ans;

    // One clock domain, so one default clocking and reset
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    // Setup phase and read answer, helpers for the properties
    assign setup = PSEL_I && !PENABLE_I;
    assign rd_ans = PREADY_O && !PWRITE_I;

    ready_zero_wait_a: assert property (setup |=> PREADY_O)
        else $error("no ready after setup");
    ready_one_cycle_a: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready held too long");
    ready_has_setup_a: assert property (PREADY_O |-> $past(setup))
        else $error("ready without setup");
    rdata_idle_zero_a: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
        else $error("read data outside answer");
    rdata_upper_zero_a: assert property (PRDATA_O[31:8] == 24'h0)
        else $error("upper read data set");
    err_with_ready_a: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    err_data_zero_a: assert property (PSLVERR_O |-> PRDATA_O == 32'h0)
        else $error("refused access returned data");
    misalign_err_a: assert property (setup && PADDR_I[1:0] != 2'h0 |=> PSLVERR_O)
        else $error("misaligned access accepted");
    duty_spare_zero_a: assert property (
        rd_ans && PADDR_I[7:2] == `SPWM_IDX_DHI |-> PRDATA_O[7:2] == 6'h00)
        else $error("duty high spare bits set");
    tmr_spare_zero_a: assert property (rd_ans && (PADDR_I[7:2] == `SPWM_IDX_TMA ||
        PADDR_I[7:2] == `SPWM_IDX_TMB) |-> !PRDATA_O[3])
        else $error("timer spare bit set");
    on_not_hiz_a: assert property (SWITCH_HIZ_O |-> !SWITCH_ON_O)
        else $error("switch on while high impedance");

    // Main scenarios reached
    cover property (PREADY_O && PSLVERR_O);
    cover property ($rose(SWITCH_ON_O));
    cover property (SWITCH_HIZ_O && PREADY_O);
endmodule

bind spwm_top spwm_top_checker u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SWITCH_ON_O(SWITCH_ON_O),
    .SWITCH_HIZ_O(SWITCH_HIZ_O));

// ===== sim/spwm_top_test.sv
// Self-checking bench for the switch PWM and interval timer block
`include "spwm_params.svh"
module spwm_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 10;
    logic clk = 1'b0;
    logic rst, psel, penable, pwrite, pwm_a, alt, pready, pslverr, sw_on, sw_hiz, ld_done;
    logic [7:0] paddr, r;
    logic [31:0] pwdata, prdata;
    logic [33:0] bus_q[$];
    logic [33:0] be;
    logic [63:0] pw_q[$];
    logic [63:0] pe;
    int ld_width, ld_period;
    int err_total = 0;
    int n_compared = 0;
    int seed = 32'h810d;
    int wu[16] = '{0, 1, 3, 5, 10, 100, 200, 300, 400, 500, 600, 800, 1000, 1500, 2000, 0};
    int pu[8] = '{100, 200, 500, 1000, 2000, 5000, 10000, 20000};
    logic [5:0] idx[6] = '{`SPWM_IDX_FREQ, `SPWM_IDX_DHI, `SPWM_IDX_DLO, `SPWM_IDX_TMA,
        `SPWM_IDX_TMB, `SPWM_IDX_CTRL};
    logic [7:0] msk[6] = '{8'h80, 8'h03, 8'hFF, 8'hF7, 8'hF7, 8'hF0};

    always #5 clk = ~clk;

    spwm_top #(.TICK_CYCLES(TICK)) dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PWM_A_I(pwm_a), .ALT_CTRL_I(alt), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .SWITCH_ON_O(sw_on), .SWITCH_HIZ_O(sw_hiz));
    spwm_load_model load (.clk_i(clk), .rst_i(rst), .on_i(sw_on), .hiz_i(sw_hiz),
        .done_o(ld_done), .width_o(ld_width), .period_o(ld_period));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // One APB transfer; the answer is noted for the monitor first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] exp, input logic err);
        bus_q.push_back({w, err, exp});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] v);
        apb(1'b1, {i, 2'b00}, {24'h0, v}, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [5:0] i, input logic [7:0] v);
        apb(1'b0, {i, 2'b00}, 32'h0, {24'h0, v}, 1'b0);
    endtask

    // Status read after the output pipeline and input sync settle
    task automatic stat(input logic [7:0] v);
        repeat (8) @(posedge clk);
        rd(`SPWM_IDX_STAT, v);
    endtask

    // Wait for the end of a lamp pulse, then step past it
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ld_done !== 1'b1 && n < 30000);
        if (ld_done !== 1'b1) err_total++;
        @(posedge clk);
    endtask

    // Two pulses skipped, as the reconfigured period may be cut short
    task automatic tmr(input logic [5:0] i, input logic [2:0] src, input int w, input int p);
        wr(i, {w[3:0], 1'b0, p[2:0]});
        wr(`SPWM_IDX_CTRL, {1'b1, src, 4'h0});
        wait_done();
        wait_done();
        pw_q.push_back({32'(pu[p] * TICK), 32'(wu[w] * TICK)});
        wait_done();
    endtask

    // Bus answers checked against the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            be = bus_q.pop_front();
            chk("slave error", {31'h0, pslverr}, {31'h0, be[32]});
            if (!be[33]) chk("read data", prdata, be[31:0]);
        end
    end

    // Lamp pulses checked against the noted timing
    always @(posedge clk) begin
        if (ld_done === 1'b1 && pw_q.size() > 0) begin
            pe = pw_q.pop_front();
            chk("on width", ld_width, pe[31:0]);
            chk("period", ld_period, pe[63:32]);
        end
    end

    // A hang counts as a mismatch
    initial begin
        #800us;
        err_total++;
        end_of_test();
    end

    initial begin
        {psel, penable, pwrite, pwm_a, alt} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values, then all ones with spare bits read back clear
        foreach (idx[k]) rd(idx[k], 8'h00);
        foreach (idx[k]) wr(idx[k], 8'hFF);
        foreach (idx[k]) rd(idx[k], msk[k]);
        // Random low byte; high bits stay 3 so tiny duty codes are avoided
        repeat (4) begin
            r = 8'($random(seed));
            wr(`SPWM_IDX_DLO, r);
            rd(`SPWM_IDX_DLO, r);
        end
        // Unmapped index and misaligned address are refused
        apb(1'b1, 8'h9C, 32'hFF, 32'h0, 1'b1);
        apb(1'b0, 8'h9C, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 8'h8D, 32'h0, 32'h0, 1'b1);
        // Every source code is stored, reserved ones too
        for (int c = 0; c < 8; c++) begin
            wr(`SPWM_IDX_CTRL, {1'b1, c[2:0], 4'hF});
            rd(`SPWM_IDX_CTRL, {1'b1, c[2:0], 4'h0});
        end
        wr(`SPWM_IDX_TMA, 8'h00);
        wr(`SPWM_IDX_TMB, 8'h00);
        wr(`SPWM_IDX_DLO, 8'hFF);
        // Reserved source code drives the switch off
        wr(`SPWM_IDX_CTRL, 8'hE0);
        stat(8'h04);
        wr(`SPWM_IDX_CTRL, 8'h80);
        stat(8'h05);
        repeat (2) begin
            r = 8'($random(seed));
            pwm_a <= r[0];
            alt <= r[1];
            wr(`SPWM_IDX_CTRL, 8'h90);
            stat({6'h01, 1'b0, r[0]});
            wr(`SPWM_IDX_CTRL, 8'hD0);
            stat({6'h01, 1'b0, r[1]});
        end
        wr(`SPWM_IDX_CTRL, 8'hA0);
        stat(8'h05);
        wr(`SPWM_IDX_DHI, 8'h00);
        wr(`SPWM_IDX_DLO, 8'h00);
        stat(8'h00);
        wr(`SPWM_IDX_CTRL, 8'h00);
        stat(8'h02);
        wr(`SPWM_IDX_CTRL, 8'hB0);
        stat(8'h02);
        wr(`SPWM_IDX_TMA, 8'hF0);
        stat(8'h09);
        // Timed pulses on both timers
        for (int w = 1; w < 5; w++) tmr(`SPWM_IDX_TMA, 3'h3, w, 0);
        tmr(`SPWM_IDX_TMB, 3'h4, 5, 1);
        tmr(`SPWM_IDX_TMB, 3'h4, 2, 2);
        end_of_test();
    end
endmodule
